// File: common/astc_pkg.sv
/*
 * Constants shared by the sequencer trigger control block: register offsets,
 * field positions and reset values.
 * Assumes a 32-bit APB with word-aligned registers.
 */
`default_nettype none

package astc_pkg;

	// ***********************************************************************
	// Register offsets (byte addresses).
	// ***********************************************************************
	localparam logic [7:0] SEQ_TRIGGER_CONTROL_OFS = 8'h00; // Trigger control register.
	localparam logic [7:0] SEQ_STATUS_OFS = 8'h04; // Sticky status register.

	// ***********************************************************************
	// Field positions of the trigger control register.
	// ***********************************************************************
	localparam int START_REQ_BIT = 13; // Software start, reads as pending start.
	localparam int IRQ_MODE_BIT = 10; // First-sequencer flag every second sequence.
	localparam int RSVD_BIT = 9; // Reserved, reads zero.
	localparam int PWM_A_EN_BIT = 8; // Conversion-start A may start the sequencer.
	localparam int EXT_EN_BIT = 7; // External line may start the sequencer.
	localparam int SECOND_SEQUENCER_RESET_BIT = 6; // Write one to reset the second sequencer.

	// ***********************************************************************
	// Field positions of the status register and reset values.
	// ***********************************************************************
	localparam int IRQ_FLAG_BIT = 0; // First-sequencer interrupt flag, write one clears.
	localparam logic [15:0] CONTROL_RESET = 16'h0000; // Control value after reset.
	localparam int REG_WIDTH = 16; // Documented register width.

endpackage : astc_pkg

`default_nettype wire

// File: hdl/astc_start_arbiter.sv
/*
 * Start arbiter for one sequencer: starts at once when idle, holds one
 * pending start while busy, and drops further triggers.
 * Assumes busy rises no later than the cycle after a start pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module astc_start_arbiter (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Trigger side.
	input wire logic trig,
	input wire logic clearPending,
	input wire logic busy,
	// Sequencer side.
	output logic start,
	output logic pending
);

	logic start_r, start_nxt; // One-cycle start pulse.
	logic pending_r, pending_nxt; // One held start request.
	logic busyEff; // Busy, covering the gap before the sequencer reports it.

	// ***********************************************************************
	// Next-state logic.
	// ***********************************************************************
	// The start pulse itself counts as busy so that a pending start is not
	// launched twice before the sequencer raises its busy line.
	always_comb begin
		busyEff = busy | start_r;
		start_nxt = 1'b0;
		pending_nxt = pending_r;
		if (!busyEff && pending_r) begin
			start_nxt = 1'b1;
			pending_nxt = 1'b0;
		end else if (trig && !busyEff) begin
			start_nxt = 1'b1;
		end else if (trig && !pending_r) begin
			pending_nxt = 1'b1;
		end else if (clearPending && !trig) begin
			// A new trigger wins over a software clear in the same cycle.
			pending_nxt = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 1'b0;
			pending_r <= 1'b0;
		end else begin
			start_r <= start_nxt;
			pending_r <= pending_nxt;
		end
	end

	assign start = start_r;
	assign pending = pending_r;

	// ***********************************************************************
	// Checks.
	// ***********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence idleTrig;
		trig && !busy && !start_r && !pending_r;
	endsequence

	a_idle_start: assert property (idleTrig |=> start_r && !pending_r)
		else $error("idle trigger did not start");
	a_busy_pend: assert property (trig && busy && !pending_r |=> pending_r && !start_r)
		else $error("busy trigger not held");
	// A software clear with no trigger beside it may legally drop the pending start.
	a_pend_drop: assert property (pending_r && busy && !(clearPending && !trig) |=> pending_r && !start_r)
		else $error("extra trigger disturbed pending start");
	a_pend_launch: assert property (pending_r && !busy && !start_r |=> start_r ##1 !start_r)
		else $error("pending start not launched once");

endmodule : astc_start_arbiter

`default_nettype wire

// File: hdl/astc_trigger_ctrl.sv
/*
 * Sequencer trigger control: APB register, trigger gating for the first
 * sequencer, interrupt-mode flag and second-sequencer reset.
 * Assumes pwmStartA and the sequencer status inputs come from logic on clk;
 * extLine comes from a pin and is synchronised here.
 */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module astc_trigger_ctrl (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger sources.
	input wire logic pwmStartA,
	input wire logic extLine,
	// First sequencer.
	input wire logic seq1Busy,
	input wire logic seq1Done,
	output logic seq1Start,
	output logic irqFlag,
	// Second sequencer.
	input wire logic seq2Busy,
	output logic seq2Reset,
	output logic seq2Abort
);

	// Control fields and status.
	logic irqMode_r, irqMode_nxt; // Flag on every second sequence when set.
	logic pwmAEn_r, pwmAEn_nxt; // Start-A enable.
	logic extEn_r, extEn_nxt; // External line enable.
	logic seq2Reset_r, seq2Reset_nxt; // One-cycle reset pulse.
	logic seq2Abort_r, seq2Abort_nxt; // One-cycle abort pulse.
	logic irqFlag_r, irqFlag_nxt; // Sticky interrupt flag.
	logic irqPhase_r, irqPhase_nxt; // Odd sequence seen in every-other mode.
	// Bus answer.
	logic [31:0] prdata_r, prdata_nxt; // Read data, loaded in the setup cycle.
	logic pslverr_r, pslverr_nxt; // Error for an unmapped address.
	logic pready_r; // Zero-wait answer after reset.
	// External line synchroniser and edge detector.
	logic extS1_r, extS2_r, extPrev_r;
	// Decoded strobes and triggers.
	logic wrEn, setupRd, ctrlHit, statHit, extRise;
	logic swStart, swClear, pwmTrig, extTrig, anyTrig, pending;

	// ***********************************************************************
	// Decode and trigger gating.
	// ***********************************************************************
	// Writes take effect only in the access cycle that completes.
	always_comb begin
		ctrlHit = (paddr == astc_pkg::SEQ_TRIGGER_CONTROL_OFS);
		statHit = (paddr == astc_pkg::SEQ_STATUS_OFS);
		wrEn = psel && penable && pready_r && pwrite;
		setupRd = psel && !penable;
		extRise = extS2_r && !extPrev_r;
		swStart = wrEn && ctrlHit && pwdata[astc_pkg::START_REQ_BIT];
		swClear = wrEn && ctrlHit && !pwdata[astc_pkg::START_REQ_BIT];
		pwmTrig = pwmStartA && pwmAEn_r;
		extTrig = extRise && extEn_r;
		anyTrig = swStart || pwmTrig || extTrig;
	end

	// ***********************************************************************
	// Start arbiter for the first sequencer.
	// ***********************************************************************
	// Only the first sequencer takes this start; the second sequencer gets only reset and abort here.
	astc_start_arbiter uArb (
		.clk(clk),
		.rst_n(rst_n),
		.trig(anyTrig),
		.clearPending(swClear),
		.busy(seq1Busy),
		.start(seq1Start),
		.pending(pending)
	);

	// ***********************************************************************
	// Register file, flag and bus answer: next values.
	// ***********************************************************************
	always_comb begin
		irqMode_nxt = irqMode_r;
		pwmAEn_nxt = pwmAEn_r;
		extEn_nxt = extEn_r;
		irqFlag_nxt = irqFlag_r;
		irqPhase_nxt = irqPhase_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		// Reset pulse for sequencer two; a start in the same write is not ours.
		seq2Reset_nxt = wrEn && ctrlHit && pwdata[astc_pkg::SECOND_SEQUENCER_RESET_BIT];
		seq2Abort_nxt = seq2Reset_nxt && seq2Busy;
		if (wrEn && ctrlHit) begin
			irqMode_nxt = pwdata[astc_pkg::IRQ_MODE_BIT];
			pwmAEn_nxt = pwdata[astc_pkg::PWM_A_EN_BIT];
			extEn_nxt = pwdata[astc_pkg::EXT_EN_BIT];
			// Bit 9 is not stored, so writes to it vanish.
		end
		// Software clear first, so a completion in the same cycle wins.
		if (wrEn && statHit && pwdata[astc_pkg::IRQ_FLAG_BIT]) begin
			irqFlag_nxt = 1'b0;
		end
		if (seq1Done) begin
			if (!irqMode_r) begin
				irqFlag_nxt = 1'b1;
			end else begin
				// Every other sequence: flag on the second of each pair.
				irqFlag_nxt = irqPhase_r ? 1'b1 : irqFlag_nxt;
				irqPhase_nxt = !irqPhase_r;
			end
		end
		// Read data is prepared in the setup cycle and held through access.
		if (setupRd) begin
			prdata_nxt = 32'h0000_0000;
			pslverr_nxt = !(ctrlHit || statHit);
			if (ctrlHit) begin
				prdata_nxt[astc_pkg::START_REQ_BIT] = pending;
				prdata_nxt[astc_pkg::IRQ_MODE_BIT] = irqMode_r;
				prdata_nxt[astc_pkg::PWM_A_EN_BIT] = pwmAEn_r;
				prdata_nxt[astc_pkg::EXT_EN_BIT] = extEn_r;
				// Bit 9 and the reset bit read zero.
				prdata_nxt[astc_pkg::RSVD_BIT] = 1'b0;
			end else if (statHit) begin
				prdata_nxt[astc_pkg::IRQ_FLAG_BIT] = irqFlag_r;
			end
		end
	end

	// ***********************************************************************
	// Registers.
	// ***********************************************************************
	// The first synchroniser stage feeds only the second.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqMode_r <= astc_pkg::CONTROL_RESET[astc_pkg::IRQ_MODE_BIT];
			pwmAEn_r <= astc_pkg::CONTROL_RESET[astc_pkg::PWM_A_EN_BIT];
			extEn_r <= astc_pkg::CONTROL_RESET[astc_pkg::EXT_EN_BIT];
			seq2Reset_r <= 1'b0;
			seq2Abort_r <= 1'b0;
			irqFlag_r <= 1'b0;
			irqPhase_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
			extS1_r <= 1'b0;
			extS2_r <= 1'b0;
			extPrev_r <= 1'b0;
		end else begin
			irqMode_r <= irqMode_nxt;
			pwmAEn_r <= pwmAEn_nxt;
			extEn_r <= extEn_nxt;
			seq2Reset_r <= seq2Reset_nxt;
			seq2Abort_r <= seq2Abort_nxt;
			irqFlag_r <= irqFlag_nxt;
			irqPhase_r <= irqPhase_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			pready_r <= 1'b1;
			extS1_r <= extLine;
			extS2_r <= extS1_r;
			extPrev_r <= extS2_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irqFlag = irqFlag_r;
	assign seq2Reset = seq2Reset_r;
	assign seq2Abort = seq2Abort_r;

	// ***********************************************************************
	// Checks.
	// ***********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence idleGate;
		!seq1Busy && !seq1Start && !pending;
	endsequence

	a_flag_every: assert property (seq1Done && !irqMode_r |=> irqFlag_r)
		else $error("flag missed in every-sequence mode");
	a_flag_skip: assert property (seq1Done && irqMode_r && !irqPhase_r && !irqFlag_r |=> !irqFlag_r)
		else $error("flag set on first of a pair");
	a_rsvd_zero: assert property (!prdata_r[astc_pkg::RSVD_BIT])
		else $error("reserved bit read nonzero");
	a_pwm_blocked: assert property (!pwmAEn_r && !swStart && !extTrig && pwmStartA |=> $stable(pending))
		else $error("disabled start-A changed pending state");
	a_pwm_start: assert property ((pwmStartA && pwmAEn_r) and idleGate |=> seq1Start)
		else $error("enabled start-A did not start");
	a_ext_start: assert property ((extS2_r && !extPrev_r && extEn_r) and idleGate |=> seq1Start)
		else $error("external line did not start");
	a_second_sequencer_reset: assert property (wrEn && ctrlHit && pwdata[astc_pkg::SECOND_SEQUENCER_RESET_BIT] |=> seq2Reset_r ##1 !seq2Reset_r)
		else $error("second sequencer reset pulse wrong");
	a_second_sequencer_abort: assert property (wrEn && ctrlHit && pwdata[astc_pkg::SECOND_SEQUENCER_RESET_BIT] && seq2Busy |=> seq2Abort_r)
		else $error("running second sequence not aborted");

endmodule : astc_trigger_ctrl

`default_nettype wire

// File: tb/astc_seq_model.sv
/*
 * Behavioural model of the two sequencers behind the trigger control block.
 * Assumes starts, resets and the second-sequencer launch arrive on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module astc_seq_model #(
	parameter int LEN = 20
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Requests from the block and the bench.
	input wire logic seq1Start,
	input wire logic seq2Reset,
	input wire logic seq2Go,
	// Status back to the block.
	output logic seq1Busy,
	output logic seq1Done,
	output logic seq2Busy
);
	int cnt; // Cycles left in the running first sequence.

	// Busy rises on the edge after a start, as the arbiter expects.
	// A long sequence leaves room to stack triggers while busy.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			seq1Busy <= 1'b0;
			seq1Done <= 1'b0;
			seq2Busy <= 1'b0;
		end else begin
			seq1Done <= (cnt == 1);
			if (seq1Start) begin
				cnt <= LEN;
				seq1Busy <= 1'b1;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
				seq1Busy <= (cnt > 1);
			end
			// The reset pulse drops a running second sequence at once.
			seq2Busy <= !seq2Reset && (seq2Go || seq2Busy);
		end
	end
endmodule : astc_seq_model

`default_nettype wire

// File: tb/astc_trigger_ctrl_tb_top.sv
/*
 * Self-checking bench for the trigger control block.
 * Assumes a zero-wait APB slave and the sequencer model beside it.
 */
`timescale 1ns/10ps
`default_nettype none

module astc_trigger_ctrl_tb_top;
	// ****************************************************************
	// Signals and bookkeeping.
	// ****************************************************************
	localparam logic [7:0] CTL = astc_pkg::SEQ_TRIGGER_CONTROL_OFS; // Control address.
	localparam logic [7:0] STS = astc_pkg::SEQ_STATUS_OFS; // Status address.
	localparam logic [31:0] MODE = 32'h1 << astc_pkg::IRQ_MODE_BIT; // Flag every second.
	localparam logic [31:0] RSV = 32'h1 << astc_pkg::RSVD_BIT; // Reserved bit.
	localparam logic [31:0] PWM = 32'h1 << astc_pkg::PWM_A_EN_BIT; // Start-A gate.
	localparam logic [31:0] EXT = 32'h1 << astc_pkg::EXT_EN_BIT; // Pin gate.
	localparam logic [31:0] R2 = 32'h1 << astc_pkg::SECOND_SEQUENCER_RESET_BIT; // Second reset.
	localparam logic [31:0] GO = 32'h1 << astc_pkg::START_REQ_BIT; // Software start.
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pwmStartA = 1'b0, extLine = 1'b0, seq2Go = 1'b0, f1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h16568600;
	logic pready, pslverr, seq1Busy, seq1Done, seq1Start, irqFlag, seq2Busy, seq2Reset, seq2Abort;
	logic [32:0] expQ[$]; // Expected {pslverr, prdata} of each read, oldest first.
	int n_fail = 0, n_tests = 0, nStart = 0, nRst = 0, nAbt = 0, cyc = 0, n0;

	astc_trigger_ctrl i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwmStartA(pwmStartA), .extLine(extLine), .seq1Busy(seq1Busy),
		.seq1Done(seq1Done), .seq1Start(seq1Start), .irqFlag(irqFlag), .seq2Busy(seq2Busy),
		.seq2Reset(seq2Reset), .seq2Abort(seq2Abort));
	astc_seq_model #(.LEN(20)) i_seq (.clk(clk), .rst_n(rst_n), .seq1Start(seq1Start),
		.seq2Reset(seq2Reset), .seq2Go(seq2Go), .seq1Busy(seq1Busy), .seq1Done(seq1Done),
		.seq2Busy(seq2Busy));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk = ~clk;
	end

	// ****************************************************************
	// Tasks.
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic summarize;
		if (n_fail == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	// Trigger pulses: start-A is one cycle wide, the pin is held for two.
	task automatic pwm;
		@(posedge clk) pwmStartA <= 1'b1;
		@(posedge clk) pwmStartA <= 1'b0;
	endtask : pwm

	task automatic pin;
		@(posedge clk) extLine <= 1'b1;
		repeat (2) @(posedge clk);
		extLine <= 1'b0;
	endtask : pin

	// Bounded wait for the first sequencer to go quiet.
	task automatic idle;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 200 && seq1Busy !== 1'b0; k++) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask : idle

	// ****************************************************************
	// Watcher: counts pulses, compares reads, cuts a hang short.
	// ****************************************************************
	always @(posedge clk) begin
		cyc++;
		if (seq1Start === 1'b1) nStart++;
		if (seq2Reset === 1'b1) nRst++;
		if (seq2Abort === 1'b1) nAbt++;
		if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
			chk("read", expQ.pop_front(), {pslverr, prdata});
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(CTL, {17'h0, astc_pkg::CONTROL_RESET});
		seed = xs(seed);
		wr(CTL, (seed & 32'hFFFF0000) | MODE | RSV | PWM | EXT | R2);
		rd(CTL, {1'b0, MODE | PWM | EXT});
		repeat (3) @(posedge clk);
		chk("seq2Reset", 33'h1, 33'(nRst));
		seed = xs(seed);
		wr(8'h08, seed);
		rd(8'h08, {1'b1, 32'h0});
		rd(CTL, {1'b0, MODE | PWM | EXT});
		// Disabled sources leave count and pending state alone.
		wr(CTL, 32'h0);
		pwm();
		pin();
		idle();
		chk("seq1Start", 33'h0, 33'(nStart));
		rd(CTL, 33'h0);
		wr(CTL, PWM);
		n0 = nStart;
		pwm();
		repeat (3) @(posedge clk);
		chk("seq1Start", 33'(n0 + 1), 33'(nStart));
		// Two triggers while busy: one held, the next lost.
		pwm();
		pwm();
		rd(CTL, {1'b0, PWM | GO});
		idle();
		idle();
		chk("seq1Start", 33'(n0 + 2), 33'(nStart));
		wr(CTL, EXT);
		n0 = nStart;
		pin();
		idle();
		chk("seq1Start", 33'(n0 + 1), 33'(nStart));
		wr(STS, 32'h1);
		wr(CTL, GO);
		idle();
		rd(STS, 33'h1);
		wr(STS, 32'h1);
		wr(CTL, MODE | GO);
		idle();
		f1 = irqFlag;
		wr(STS, 32'h1);
		wr(CTL, MODE | GO);
		idle();
		// The first of the pair must leave the flag clear, the second must set it.
		chk("irqFlag", 33'h1, {31'h0, f1, irqFlag});
		// Second sequencer reset with and without a running sequence.
		@(posedge clk) seq2Go <= 1'b1;
		@(posedge clk) seq2Go <= 1'b0;
		wr(CTL, R2);
		repeat (3) @(posedge clk);
		chk("seq2Abort", 33'h1, 33'(nAbt));
		n0 = nStart;
		wr(CTL, R2);
		wr(CTL, GO);
		idle();
		chk("seq2Reset", 33'h3, 33'(nRst));
		chk("seq2Abort", 33'h1, 33'(nAbt));
		chk("seq1Start", 33'(n0 + 1), 33'(nStart));
		summarize();
	end
endmodule : astc_trigger_ctrl_tb_top

`default_nettype wire
